// ===== logic/mpsc_input_cond.sv
// two-stage synchroniser, debounce filter and falling-edge pulse for one input
`timescale 1ns/1ps
module mpsc_input_cond #(
  parameter int unsigned DEB_CYC = 1
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin_n,
  output logic      level_n,
  output logic      fall_pulse
);
  import mpsc_pkg::*;

  localparam int unsigned CW = (DEB_CYC > 1) ? $clog2(DEB_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(DEB_CYC - 1);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          stable;
    logic [CW-1:0] cnt;
    logic          fall;
  } mpsc_cond_t;

  mpsc_cond_t r_r;
  mpsc_cond_t r_nxt;

  always_comb
  begin
    r_nxt      = r_r;
    r_nxt.s1   = pin_n;
    r_nxt.s2   = r_r.s1;
    r_nxt.fall = 1'b0;
    if (r_r.s2 == r_r.stable)
    begin
      r_nxt.cnt = '0;
    end
    else if (r_r.cnt == LAST)
    begin
      // level must differ for DEB_CYC cycles in a row, so bounce yields one edge
      r_nxt.stable = r_r.s2;
      r_nxt.cnt    = '0;
      r_nxt.fall   = r_r.stable;
    end
    else
    begin
      r_nxt.cnt = r_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      r_r <= '{s1: 1'b1, s2: 1'b1, stable: 1'b1, cnt: '0, fall: 1'b0};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign level_n    = r_r.stable;
  assign fall_pulse = r_r.fall;
endmodule : mpsc_input_cond

// ===== logic/mpsc_pkg.sv
// shared constants and state encoding for the module power-state control block
package mpsc_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  // input filtering: least time a button level must stand before it counts
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYC   = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
  // least time the carrier reset stays low after supply good
  localparam int unsigned RST_HOLD_MS    = 1;
  localparam int unsigned RST_HOLD_CYC   = (RST_HOLD_MS * CLK_HZ + 999) / 1000;
  // least lead time of the suspend warning before the low-power state is entered
  localparam int unsigned WARN_LEAD_US   = 1;
  localparam int unsigned WARN_LEAD_CYC  = (WARN_LEAD_US * (CLK_HZ / 1000) + 999) / 1000;
  // watchdog expiry time without a retrigger
  localparam int unsigned WDT_TIMEOUT_S  = 1;
  localparam int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_S * CLK_HZ;
  localparam int unsigned TMR_W          = 32;

  // conditioned input channel indices
  localparam int unsigned IX_PWR = 0;
  localparam int unsigned IX_RST = 1;
  localparam int unsigned IX_LID = 2;
  localparam int unsigned IX_SLP = 3;
  localparam int unsigned IX_PGD = 4;
  localparam int unsigned IX_WK0 = 5;
  localparam int unsigned IX_WK1 = 6;
  localparam int unsigned IX_BAT = 7;
  localparam int unsigned IX_THR = 8;
  localparam int unsigned NCH    = 9;
  // channels that carry a mechanical contact and need debouncing
  localparam int unsigned NDEB   = 4;

  typedef enum logic [2:0] {
    PS_OFF     = 3'b000,
    PS_WAIT_PG = 3'b001,
    PS_BOOT    = 3'b010,
    PS_WORK    = 3'b011,
    PS_WARN    = 3'b100,
    PS_SLEEP   = 3'b101
  } mpsc_state_t;
endpackage : mpsc_pkg

// ===== logic/mpsc_power_ctrl.sv
// power-state, reset, suspend, watchdog and thermal control of the plug-in module
`timescale 1ns/1ps
// Behaviour
// - in ATX mode a power button press powers on from off, powers off from working or waiting for supply good, and wakes from sleep.
// - a reset button press in working restarts boot: carrier reset held low again, main power stays on.
// - drive an active-low system reset output for carrier devices.
// - hold boot until supply good is high, then start booting.
// - drive suspend warning low before entering a low-power state, except on an internal trip, which drives it low as it enters off.
// - suspend-to-RAM output low during S3; carrier removes S3 power.
// - soft-off output low during S5; hibernate output is the same signal.
// - PCI Express wake low powers the module on; open reads inactive.
// - general wake low powers the module on, handled on its own channel.
// - battery-low low level is reported as a battery event; open is inactive.
// - lid switch press moves between working and sleep either way.
// - sleep button press moves between working and sleep either way.
// - watchdog output goes high when the timer expires without retrigger.
// - throttle the processor while the overheat alarm is held low.
// - thermal shutdown output goes low when an overheating shutdown begins.
module mpsc_power_ctrl #(
  parameter int unsigned DEB_CYC  = mpsc_pkg::DEBOUNCE_CYC,
  parameter int unsigned RST_CYC  = mpsc_pkg::RST_HOLD_CYC,
  parameter int unsigned WARN_CYC = mpsc_pkg::WARN_LEAD_CYC,
  parameter int unsigned WDT_CYC  = mpsc_pkg::WDT_TIMEOUT_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic atx_mode,
  input  wire logic power_button_n,
  input  wire logic reset_button_n,
  input  wire logic supply_good_in,
  input  wire logic pcie_wake_in_n,
  input  wire logic general_wake_in_n,
  input  wire logic battery_low_in_n,
  input  wire logic lid_switch_in_n,
  input  wire logic sleep_button_in_n,
  input  wire logic overheat_alarm_in_n,
  input  wire logic cpu_trip,
  input  wire logic watchdog_enable,
  input  wire logic watchdog_kick,
  output logic      main_power_on,
  output logic      carrier_reset_out_n,
  output logic      suspend_warning_n,
  output logic      suspend_ram_state_n,
  output logic      soft_off_state_n,
  output logic      hibernate_state_n,
  output logic      watchdog_expired_out,
  output logic      thermal_shutdown_out_n,
  output logic      throttle_out,
  output logic      battery_low_out,
  output mpsc_pkg::mpsc_state_t power_state
);
  import mpsc_pkg::*;

  localparam logic [TMR_W-1:0] RST_LAST  = TMR_W'(RST_CYC - 1);
  localparam logic [TMR_W-1:0] WARN_LAST = TMR_W'(WARN_CYC - 1);
  localparam logic [TMR_W-1:0] WDT_LAST  = TMR_W'(WDT_CYC - 1);

  typedef struct packed {
    mpsc_state_t      st;
    logic             to_off;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] wdt;
    logic             pwr;
    logic             rst_n;
    logic             warn_n;
    logic             s3_n;
    logic             s5_n;
    logic             wdt_exp;
    logic             trip_n;
    logic             thr;
    logic             bat;
  } mpsc_ctrl_t;

  mpsc_ctrl_t r_r;
  mpsc_ctrl_t r_nxt;

  logic [NCH-1:0] raw_n;
  logic [NCH-1:0] lvl_n;
  logic [NCH-1:0] fall;

  assign raw_n[IX_PWR] = power_button_n;
  assign raw_n[IX_RST] = reset_button_n;
  assign raw_n[IX_LID] = lid_switch_in_n;
  assign raw_n[IX_SLP] = sleep_button_in_n;
  assign raw_n[IX_PGD] = ~supply_good_in;
  assign raw_n[IX_WK0] = pcie_wake_in_n;
  assign raw_n[IX_WK1] = general_wake_in_n;
  assign raw_n[IX_BAT] = battery_low_in_n;
  assign raw_n[IX_THR] = overheat_alarm_in_n;

  // buttons get the long filter; level inputs only the synchroniser
  for (genvar i = 0; i < NCH; i++)
  begin : g_cond
    mpsc_input_cond #(
      .DEB_CYC (i < NDEB ? DEB_CYC : 1)
    ) u_cond (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .pin_n      (raw_n[i]),
      .level_n    (lvl_n[i]),
      .fall_pulse (fall[i])
    );
  end

  logic pg;
  logic wake;
  logic pwr_press;
  logic sleep_press;

  always_comb
  begin
    pg          = ~lvl_n[IX_PGD];
    // wake sources are separate channels, each enough on its own
    wake        = ~lvl_n[IX_WK0] | ~lvl_n[IX_WK1];
    pwr_press   = atx_mode & fall[IX_PWR];
    sleep_press = fall[IX_LID] | fall[IX_SLP];
  end

  always_comb
  begin
    r_nxt     = r_r;
    r_nxt.thr = ~lvl_n[IX_THR];
    r_nxt.bat = ~lvl_n[IX_BAT];
    r_nxt.tmr = r_r.tmr + TMR_W'(1);
    case (r_r.st)
      PS_OFF:
      begin
        r_nxt.pwr   = 1'b0;
        r_nxt.rst_n = 1'b0;
        r_nxt.s3_n  = 1'b0;
        r_nxt.s5_n  = 1'b0;
        // without ATX mode the power button is ignored: power comes on at once
        if (pwr_press || wake || !atx_mode)
        begin
          r_nxt.st     = PS_WAIT_PG;
          r_nxt.pwr    = 1'b1;
          r_nxt.s3_n   = 1'b1;
          r_nxt.s5_n   = 1'b1;
          r_nxt.warn_n = 1'b1;
          r_nxt.trip_n = 1'b1;
        end
      end
      PS_WAIT_PG:
      begin
        r_nxt.rst_n = 1'b0;
        r_nxt.tmr   = '0;
        if (pwr_press)
        begin
          r_nxt.st     = PS_WARN;
          r_nxt.to_off = 1'b1;
        end
        else if (pg)
        begin
          r_nxt.st = PS_BOOT;
        end
      end
      PS_BOOT:
      begin
        r_nxt.rst_n = 1'b0;
        r_nxt.wdt   = '0;
        if (!pg)
        begin
          r_nxt.st = PS_WAIT_PG;
        end
        else if (r_r.tmr >= RST_LAST)
        begin
          r_nxt.st    = PS_WORK;
          r_nxt.rst_n = 1'b1;
        end
      end
      PS_WORK:
      begin
        r_nxt.tmr = '0;
        if (!watchdog_enable || watchdog_kick)
        begin
          r_nxt.wdt = '0;
          if (watchdog_kick)
          begin
            r_nxt.wdt_exp = 1'b0;
          end
        end
        else if (r_r.wdt >= WDT_LAST)
        begin
          r_nxt.wdt     = '0;
          r_nxt.wdt_exp = 1'b1;
        end
        else
        begin
          r_nxt.wdt = r_r.wdt + TMR_W'(1);
        end
        if (!pg)
        begin
          r_nxt.st    = PS_WAIT_PG;
          r_nxt.rst_n = 1'b0;
        end
        else if (fall[IX_RST])
        begin
          r_nxt.st      = PS_BOOT;
          r_nxt.rst_n   = 1'b0;
          r_nxt.wdt_exp = 1'b0;
        end
        else if (pwr_press || sleep_press)
        begin
          r_nxt.st     = PS_WARN;
          r_nxt.to_off = pwr_press;
          r_nxt.warn_n = 1'b0;
        end
      end
      PS_WARN:
      begin
        r_nxt.warn_n = 1'b0;
        if (r_r.tmr >= WARN_LAST)
        begin
          r_nxt.rst_n = 1'b0;
          r_nxt.s3_n  = 1'b0;
          if (r_r.to_off)
          begin
            r_nxt.st   = PS_OFF;
            r_nxt.s5_n = 1'b0;
            r_nxt.pwr  = 1'b0;
          end
          else
          begin
            r_nxt.st = PS_SLEEP;
          end
        end
      end
      PS_SLEEP:
      begin
        r_nxt.s3_n = 1'b0;
        r_nxt.tmr  = '0;
        if (sleep_press || pwr_press || wake)
        begin
          r_nxt.st     = PS_WAIT_PG;
          r_nxt.s3_n   = 1'b1;
          r_nxt.warn_n = 1'b1;
        end
      end
      default:
      begin
        r_nxt.st = PS_OFF;
      end
    endcase
    // an internal trip overrides every state but PS_OFF: shut down and flag it
    if (cpu_trip && r_r.st != PS_OFF)
    begin
      r_nxt.st     = PS_OFF;
      r_nxt.trip_n = 1'b0;
      r_nxt.pwr    = 1'b0;
      r_nxt.rst_n  = 1'b0;
      r_nxt.warn_n = 1'b0;
      r_nxt.s3_n   = 1'b0;
      r_nxt.s5_n   = 1'b0;
    end
    if (r_nxt.st != r_r.st)
    begin
      r_nxt.tmr = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      r_r <= '{st: PS_OFF, to_off: 1'b0, tmr: '0, wdt: '0, pwr: 1'b0, rst_n: 1'b0,
               warn_n: 1'b0, s3_n: 1'b0, s5_n: 1'b0, wdt_exp: 1'b0, trip_n: 1'b1,
               thr: 1'b0, bat: 1'b0};
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign main_power_on          = r_r.pwr;
  assign carrier_reset_out_n    = r_r.rst_n;
  assign suspend_warning_n      = r_r.warn_n;
  assign suspend_ram_state_n    = r_r.s3_n;
  // hibernate and soft-off share one flop so they can never disagree
  assign soft_off_state_n       = r_r.s5_n;
  assign hibernate_state_n      = r_r.s5_n;
  assign watchdog_expired_out   = r_r.wdt_exp;
  assign thermal_shutdown_out_n = r_r.trip_n;
  assign throttle_out           = r_r.thr;
  assign battery_low_out        = r_r.bat;
  assign power_state            = r_r.st;
endmodule : mpsc_power_ctrl

// ===== verification/module_power_state_control_test.sv
// self-checking bench of the module power-state control block
`timescale 1ns/1ps
module module_power_state_control_test;
  import mpsc_pkg::*;
  logic ref_clk = 0, resetn = 0, atx_mode = 1, cpu_trip = 0, pg_fault = 0;
  logic watchdog_enable = 0, watchdog_kick = 0;
  logic [3:0] btn = 4'hf;
  logic [3:0] lvl = 4'hf;
  logic supply_good_in, main_power_on, carrier_reset_out_n, suspend_warning_n;
  logic suspend_ram_state_n, soft_off_state_n, hibernate_state_n, watchdog_expired_out;
  logic thermal_shutdown_out_n, throttle_out, battery_low_out;
  mpsc_state_t power_state;
  int n_fail = 0, total_checks = 0;
  // buttons: power, reset, lid, sleep; levels: pcie wake, general wake, battery, alarm
  wire power_button_n = btn[0], reset_button_n = btn[1];
  wire lid_switch_in_n = btn[2], sleep_button_in_n = btn[3];
  wire pcie_wake_in_n = lvl[0], general_wake_in_n = lvl[1];
  wire battery_low_in_n = lvl[2], overheat_alarm_in_n = lvl[3];

  always #12.5 ref_clk = ~ref_clk;

  mpsc_carrier_model mpsc_carrier_model_i (.ref_clk, .main_power_on, .pg_fault,
    .supply_good_in);
  // short counts keep the run brief
  mpsc_power_ctrl #(.DEB_CYC(4), .RST_CYC(8), .WARN_CYC(2), .WDT_CYC(20)) mpsc_power_ctrl_i (
    .ref_clk, .resetn, .atx_mode, .power_button_n, .reset_button_n, .supply_good_in,
    .pcie_wake_in_n, .general_wake_in_n, .battery_low_in_n, .lid_switch_in_n,
    .sleep_button_in_n, .overheat_alarm_in_n, .cpu_trip, .watchdog_enable, .watchdog_kick,
    .main_power_on, .carrier_reset_out_n, .suspend_warning_n, .suspend_ram_state_n,
    .soft_off_state_n, .hibernate_state_n, .watchdog_expired_out, .thermal_shutdown_out_n,
    .throttle_out, .battery_low_out, .power_state);

  task automatic chk(string what, logic [2:0] exp, logic [2:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wait_st(mpsc_state_t s);
    int n = 0;
    while (power_state !== s && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("power_state", s, power_state);
  endtask : wait_st

  // a held press outlasts the filter; a short one is a bounce
  task automatic press(int i, int n);
    @(posedge ref_clk) btn[i] <= 1'b0;
    repeat (n) @(posedge ref_clk);
    btn[i] <= 1'b1;
  endtask : press

  task automatic t_power_on();
    press(0, 8);
    wait_st(PS_BOOT);
    chk("carrier_reset_out_n", 0, carrier_reset_out_n);
    wait_st(PS_WORK);
    chk("carrier_reset_out_n", 1, carrier_reset_out_n);
    chk("main_power_on", 1, main_power_on);
    chk("suspend_ram_state_n", 1, suspend_ram_state_n);
    chk("hibernate_state_n", 1, hibernate_state_n);
  endtask : t_power_on

  task automatic t_sleep(int b, int w);
    press(b, 2);
    repeat (10) @(posedge ref_clk);
    #1 chk("power_state", PS_WORK, power_state);
    press(b, 8);
    wait_st(PS_WARN);
    chk("suspend_warning_n", 0, suspend_warning_n);
    wait_st(PS_SLEEP);
    chk("suspend_ram_state_n", 0, suspend_ram_state_n);
    @(posedge ref_clk) lvl[w] <= 1'b0;
    wait_st(PS_WAIT_PG);
    @(posedge ref_clk) lvl[w] <= 1'b1;
    wait_st(PS_WORK);
  endtask : t_sleep

  task automatic t_reset_and_pg();
    press(1, 8);
    wait_st(PS_BOOT);
    chk("carrier_reset_out_n", 0, carrier_reset_out_n);
    wait_st(PS_WORK);
    @(posedge ref_clk) pg_fault <= 1'b1;
    wait_st(PS_WAIT_PG);
    @(posedge ref_clk) pg_fault <= 1'b0;
    wait_st(PS_WORK);
  endtask : t_reset_and_pg

  task automatic t_wdt_levels();
    @(posedge ref_clk) watchdog_enable <= 1'b1;
    lvl[3:2] <= 2'b00;
    repeat (15) @(posedge ref_clk);
    #1 chk("watchdog_expired_out", 0, watchdog_expired_out);
    chk("throttle_out", 1, throttle_out);
    chk("battery_low_out", 1, battery_low_out);
    repeat (12) @(posedge ref_clk);
    #1 chk("watchdog_expired_out", 1, watchdog_expired_out);
    @(posedge ref_clk) watchdog_kick <= 1'b1;
    watchdog_enable <= 1'b0;
    lvl[3:2] <= 2'b11;
    @(posedge ref_clk) watchdog_kick <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk("watchdog_expired_out", 0, watchdog_expired_out);
    chk("throttle_out", 0, throttle_out);
    chk("battery_low_out", 0, battery_low_out);
  endtask : t_wdt_levels

  task automatic t_off_trip();
    press(0, 8);
    wait_st(PS_OFF);
    chk("soft_off_state_n", 0, soft_off_state_n);
    chk("hibernate_state_n", 0, hibernate_state_n);
    chk("main_power_on", 0, main_power_on);
    // the released button must settle high again, or the next press makes no edge
    repeat (10) @(posedge ref_clk);
    t_power_on();
    @(posedge ref_clk) cpu_trip <= 1'b1;
    wait_st(PS_OFF);
    chk("thermal_shutdown_out_n", 0, thermal_shutdown_out_n);
    @(posedge ref_clk) cpu_trip <= 1'b0;
  endtask : t_off_trip

  // AT mode powers up on its own and ignores the button; then a mid-run reset
  task automatic t_at_mode();
    @(posedge ref_clk) atx_mode <= 1'b0;
    wait_st(PS_WORK);
    chk("thermal_shutdown_out_n", 1, thermal_shutdown_out_n);
    press(0, 8);
    repeat (10) @(posedge ref_clk);
    #1 chk("power_state", PS_WORK, power_state);
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("main_power_on", 0, main_power_on);
    chk("carrier_reset_out_n", 0, carrier_reset_out_n);
    chk("power_state", PS_OFF, power_state);
    @(posedge ref_clk) resetn <= 1'b1;
    wait_st(PS_WORK);
    chk("carrier_reset_out_n", 1, carrier_reset_out_n);
  endtask : t_at_mode

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // the whole sequence needs well under 2000 cycles
  initial
  begin
    #125us;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_power_on();
    t_sleep(2, 0);
    t_sleep(3, 1);
    t_reset_and_pg();
    t_wdt_levels();
    t_off_trip();
    t_at_mode();
    print_verdict();
  end
endmodule : module_power_state_control_test

// ===== verification/mpsc_carrier_model.sv
// carrier supply model: raises supply good some cycles after main power comes on
`timescale 1ns/1ps
module mpsc_carrier_model #(
  parameter int unsigned PG_DLY = 5
) (
  input  wire logic ref_clk,
  input  wire logic main_power_on,
  input  wire logic pg_fault,
  output logic      supply_good_in
);
  int unsigned cnt = 0;
  initial supply_good_in = 1'b0;
  // supply good only once the rail has settled, dropped at once on a fault
  always @(posedge ref_clk)
  begin
    cnt <= main_power_on ? ((cnt < PG_DLY) ? cnt + 1 : cnt) : 0;
    supply_good_in <= main_power_on && (cnt == PG_DLY) && !pg_fault;
  end
endmodule : mpsc_carrier_model

// ===== verification/mpsc_power_ctrl_asserts.sv
// concurrent checks on the ports of the power-state control block
`timescale 1ns/1ps
module mpsc_power_ctrl_asserts
  import mpsc_pkg::*;
#(
  parameter int unsigned RST_CYC = RST_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic battery_low_in_n,
  input wire logic overheat_alarm_in_n,
  input wire logic watchdog_enable,
  input wire logic watchdog_kick,
  input wire logic main_power_on,
  input wire logic carrier_reset_out_n,
  input wire logic suspend_warning_n,
  input wire logic suspend_ram_state_n,
  input wire logic soft_off_state_n,
  input wire logic hibernate_state_n,
  input wire logic watchdog_expired_out,
  input wire logic thermal_shutdown_out_n,
  input wire logic throttle_out,
  input wire logic battery_low_out,
  input wire mpsc_state_t power_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int unsigned boot_cnt;
  always_ff @(posedge ref_clk)
    boot_cnt <= (power_state == PS_BOOT) ? boot_cnt + 1 : 0;

  property p_hib; hibernate_state_n == soft_off_state_n; endproperty
  a_hib: assert property (p_hib) else $error("hibernate differs from soft off");
  property p_off; power_state == PS_OFF |-> !soft_off_state_n && !main_power_on; endproperty
  a_off: assert property (p_off) else $error("off outputs wrong");
  property p_work;
    power_state == PS_WORK |-> carrier_reset_out_n && main_power_on && suspend_warning_n
      && suspend_ram_state_n && soft_off_state_n;
  endproperty
  a_work: assert property (p_work) else $error("working outputs wrong");
  property p_sleep;
    power_state == PS_SLEEP |-> !suspend_ram_state_n && !suspend_warning_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_warn_lead;
    power_state == PS_SLEEP && $past(power_state) != PS_SLEEP |->
      $past(power_state) == PS_WARN && !$past(suspend_warning_n);
  endproperty
  a_warn_lead: assert property (p_warn_lead) else $error("sleep without warning");
  property p_boot_hold;
    power_state == PS_BOOT ##1 power_state == PS_WORK |-> boot_cnt >= RST_CYC;
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot reset too short");
  property p_wdt_rise;
    $rose(watchdog_expired_out) |-> $past(watchdog_enable) && !$past(watchdog_kick);
  endproperty
  a_wdt_rise: assert property (p_wdt_rise) else $error("watchdog fired wrongly");
  property p_wdt_hold;
    watchdog_expired_out && !watchdog_kick |=> watchdog_expired_out || power_state == PS_BOOT;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog flag lost");
  property p_trip; $fell(thermal_shutdown_out_n) |-> power_state == PS_OFF; endproperty
  a_trip: assert property (p_trip) else $error("trip without shutdown");
  // the pin history is only meaningful once four edges have passed out of reset
  property p_thr;
    $past(resetn, 4) |-> throttle_out == !$past(overheat_alarm_in_n, 4);
  endproperty
  a_thr: assert property (p_thr) else $error("throttle wrong");
  property p_bat;
    $past(resetn, 4) |-> battery_low_out == !$past(battery_low_in_n, 4);
  endproperty
  a_bat: assert property (p_bat) else $error("battery low wrong");
  c_sleep: cover property (power_state == PS_SLEEP);
  c_trip: cover property ($fell(thermal_shutdown_out_n));
  c_wdt: cover property ($rose(watchdog_expired_out));
endmodule : mpsc_power_ctrl_asserts

bind mpsc_power_ctrl mpsc_power_ctrl_asserts #(.RST_CYC(RST_CYC)) mpsc_power_ctrl_asserts_i (
  .ref_clk, .resetn, .battery_low_in_n, .overheat_alarm_in_n, .watchdog_enable,
  .watchdog_kick, .main_power_on, .carrier_reset_out_n, .suspend_warning_n,
  .suspend_ram_state_n, .soft_off_state_n, .hibernate_state_n, .watchdog_expired_out,
  .thermal_shutdown_out_n, .throttle_out, .battery_low_out, .power_state);
